// File: pkg/scgc_pkg.sv
package scgc_pkg;

  localparam logic [7:0]  SCGC_OFF_CLK_CTRL  = 8'ha4;
  localparam logic [7:0]  SCGC_OFF_CAP_HDR   = 8'ha8;
  localparam logic [7:0]  SCGC_OFF_CARD_ID   = 8'hac;
  localparam logic [7:0]  SCGC_OFF_SI_LOAD   = 8'hc0;

  localparam int          SCGC_BIT_DEV2      = 9;
  localparam int          SCGC_BIT_DEV3      = 10;
  localparam int          SCGC_BIT_DEV4      = 11;
  localparam int          SCGC_BIT_FBK       = 12;
  localparam int          SCGC_BIT_STOPPED   = 13;
  localparam int          SCGC_BIT_RUN_EN    = 14;
  localparam int          SCGC_BIT_RUN_MODE  = 15;

  localparam logic [7:0]  SCGC_CAP_ID        = 8'h0d;
  localparam logic [7:0]  SCGC_NEXT_PCIE     = 8'hb0;
  localparam logic [7:0]  SCGC_NEXT_SLOT_ID  = 8'ha0;
  localparam logic [3:0]  SCGC_GATE_RST      = 4'h0;
  localparam logic [15:0] SCGC_CARD_VID_RST  = 16'h0000;
  localparam logic [15:0] SCGC_CARD_ID_RST   = 16'h0000;
  localparam logic [31:0] SCGC_CLK_RST_VAL   = 32'h00000000;

  localparam logic [2:0]  SCGC_DIV_LAST      = 3'h3;

  typedef enum logic {SCGC_RUN, SCGC_STOP} scgc_run_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } scgc_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } scgc_apb_rsp_s;

endpackage

// File: rtl/scgc_top.sv
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module scgc_top
  import scgc_pkg::*;
#(
  parameter logic [15:0] CARD_VID = 16'h5a5a, // arbitrary value
  parameter logic [15:0] CARD_ID  = 16'h3c3c  // arbitrary value
) (
  input  wire logic          clk_sys,
  input  wire logic          nrst,
  input  wire scgc_apb_req_s apb_req,
  output scgc_apb_rsp_s      apb_rsp,
  input  wire logic          forward_mode,
  input  wire logic          pm_d3hot,
  input  wire logic          sec_bus_idle,
  input  wire logic          primary_req_pending,
  input  wire logic          cfgmem_load_valid,
  input  wire logic          cfgmem_slot_id_en,
  input  wire logic [15:0]   cfgmem_card_vid,
  input  wire logic [15:0]   cfgmem_card_id,
  output logic               dev2_clock_out,
  output logic               dev3_clock_out,
  output logic               dev4_clock_out,
  output logic               bridge_feedback_clock_out,
  output logic               secondary_clock_output,
  output logic               sec_clock_stopped
);

  logic [3:0]   gate_ff;
  logic         run_en_ff;
  logic         run_mode_ff;
  scgc_run_e    run_state_ff;
  logic         slot_id_en_ff;
  logic [15:0]  card_vid_ff;
  logic [15:0]  card_id_ff;
  logic [2:0]   div_ff;
  logic         phase_ff;
  logic [31:0]  rdata_ff;
  logic         ready_ff;
  logic         err_ff;

  function automatic logic gated(input logic stop_bit, input logic fwd);
    gated = fwd & stop_bit;
  endfunction

  // bus decode
  wire          setup_ph   = apb_req.psel & ~apb_req.penable;
  wire          hit_ctrl   = apb_req.paddr == SCGC_OFF_CLK_CTRL;
  wire          hit_hdr    = apb_req.paddr == SCGC_OFF_CAP_HDR;
  wire          hit_card   = apb_req.paddr == SCGC_OFF_CARD_ID;
  wire          hit_si     = apb_req.paddr == SCGC_OFF_SI_LOAD;
  wire          mapped     = hit_ctrl | hit_hdr | hit_card | hit_si;
  wire          wr_ctrl    = setup_ph & apb_req.pwrite & hit_ctrl;
  wire [7:0]    next_link  = slot_id_en_ff ? SCGC_NEXT_SLOT_ID : SCGC_NEXT_PCIE;

  // stop decision
  wire          mode_ok    = run_mode_ff ? (sec_bus_idle & ~primary_req_pending)
                                         : pm_d3hot;
  wire          want_stop  = run_en_ff & mode_ok;
  wire          phase_tick = div_ff == SCGC_DIV_LAST;

  wire [31:0]   ctrl_rd    = {16'h0000, run_mode_ff, run_en_ff,
                              run_state_ff == SCGC_STOP,
                              gate_ff, 9'h000};
  wire [31:0]   hdr_rd     = {16'h0000, next_link, SCGC_CAP_ID};
  wire [31:0]   card_rd    = {card_id_ff, card_vid_ff};
  wire [31:0]   si_rd      = {31'h00000000, slot_id_en_ff};
  wire [31:0]   nxt_rdata  = hit_ctrl ? ctrl_rd :
                             hit_hdr  ? hdr_rd  :
                             hit_card ? card_rd :
                             hit_si   ? si_rd   : 32'h00000000;

  wire          nxt_ready  = setup_ph;

  // registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      gate_ff     <= SCGC_GATE_RST;
      run_en_ff   <= SCGC_CLK_RST_VAL[SCGC_BIT_RUN_EN];
      run_mode_ff <= SCGC_CLK_RST_VAL[SCGC_BIT_RUN_MODE];
    end else if (wr_ctrl) begin
      gate_ff     <= apb_req.pwdata[SCGC_BIT_FBK:SCGC_BIT_DEV2];
      run_en_ff   <= apb_req.pwdata[SCGC_BIT_RUN_EN];
      run_mode_ff <= apb_req.pwdata[SCGC_BIT_RUN_MODE];
    end
  end

  // config-memory load
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      slot_id_en_ff <= 1'b0;
      card_vid_ff   <= SCGC_CARD_VID_RST;
      card_id_ff    <= SCGC_CARD_ID_RST;
    end else if (cfgmem_load_valid) begin
      slot_id_en_ff <= cfgmem_slot_id_en;
      card_vid_ff   <= cfgmem_card_vid;
      card_id_ff    <= cfgmem_card_id;
    end
  end

  // unloaded ids read back the parameters from reset until the first config-memory load
  logic loaded_ff;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      loaded_ff <= 1'b0;
    end else if (cfgmem_load_valid) begin
      loaded_ff <= 1'b1;
    end
  end

  // apb answer, one wait-free access phase
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ready_ff <= nxt_ready;
      err_ff   <= setup_ph & ~mapped;
      if (setup_ph) begin
        rdata_ff <= loaded_ff | ~hit_card ? nxt_rdata : {CARD_ID, CARD_VID};
      end
    end
  end

  // clock-run state
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      run_state_ff <= SCGC_RUN;
    end else begin
      case (run_state_ff)
        SCGC_RUN: begin
          if (want_stop && !phase_ff && !phase_tick) begin
            run_state_ff <= SCGC_STOP;
          end
        end
        SCGC_STOP: begin
          if (!want_stop) begin
            run_state_ff <= SCGC_RUN;
          end
        end
        default: begin
          run_state_ff <= SCGC_RUN;
        end
      endcase
    end
  end

  // secondary clock divider
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      div_ff   <= 3'h0;
      phase_ff <= 1'b0;
    end else if (phase_tick) begin
      div_ff   <= 3'h0;
      phase_ff <= run_state_ff == SCGC_STOP ? 1'b0 : ~phase_ff;
    end else begin
      div_ff   <= div_ff + 3'h1;
    end
  end

  // output pins
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dev2_clock_out            <= 1'b0;
      dev3_clock_out            <= 1'b0;
      dev4_clock_out            <= 1'b0;
      bridge_feedback_clock_out <= 1'b0;
      secondary_clock_output    <= 1'b0;
      sec_clock_stopped         <= 1'b0;
    end else begin
      dev2_clock_out            <= phase_ff & ~gated(gate_ff[0], forward_mode);
      dev3_clock_out            <= phase_ff & ~gated(gate_ff[1], forward_mode);
      dev4_clock_out            <= phase_ff & ~gated(gate_ff[2], forward_mode);
      bridge_feedback_clock_out <= phase_ff & ~gated(gate_ff[3], forward_mode);
      secondary_clock_output    <= phase_ff;
      sec_clock_stopped         <= run_state_ff == SCGC_STOP;
    end
  end

  assign apb_rsp.pready  = ready_ff;
  assign apb_rsp.pslverr = err_ff;
  assign apb_rsp.prdata  = rdata_ff;

  // assertions
  property p_gate_low;
    @(posedge clk_sys) disable iff (!nrst)
      forward_mode && gate_ff[0] |=> !dev2_clock_out;
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("dev2 clock not held low");

  property p_dev3_low;
    @(posedge clk_sys) disable iff (!nrst)
      forward_mode && gate_ff[1] |=> !dev3_clock_out;
  endproperty
  a_dev3_low: assert property (p_dev3_low) else $error("dev3 clock not held low");

  property p_dev4_low;
    @(posedge clk_sys) disable iff (!nrst)
      forward_mode && gate_ff[2] |=> !dev4_clock_out;
  endproperty
  a_dev4_low: assert property (p_dev4_low) else $error("dev4 clock not held low");

  property p_run_ok;
    @(posedge clk_sys) disable iff (!nrst)
      forward_mode && !gate_ff[0] |=> dev2_clock_out == secondary_clock_output;
  endproperty
  a_run_ok: assert property (p_run_ok) else $error("dev2 clock not running");

  property p_gate_wr;
    @(posedge clk_sys) disable iff (!nrst)
      wr_ctrl |=> gate_ff == $past(apb_req.pwdata[SCGC_BIT_FBK:SCGC_BIT_DEV2]);
  endproperty
  a_gate_wr: assert property (p_gate_wr) else $error("gate bits not written");

  property p_fbk_low;
    @(posedge clk_sys) disable iff (!nrst)
      forward_mode && gate_ff[3] |=> !bridge_feedback_clock_out;
  endproperty
  a_fbk_low: assert property (p_fbk_low) else $error("feedback clock not held low");

  property p_status;
    @(posedge clk_sys) disable iff (!nrst)
      sec_clock_stopped |-> !secondary_clock_output && !dev2_clock_out && !dev3_clock_out &&
                            !dev4_clock_out && !bridge_feedback_clock_out;
  endproperty
  a_status: assert property (p_status) else $error("clock toggles while stopped");

  property p_stat_read;
    @(posedge clk_sys) disable iff (!nrst)
      setup_ph && hit_ctrl |=> apb_rsp.prdata[SCGC_BIT_STOPPED] == $past(run_state_ff == SCGC_STOP);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("stop status misread");

  property p_en_write;
    @(posedge clk_sys) disable iff (!nrst)
      wr_ctrl |=> run_en_ff == $past(apb_req.pwdata[SCGC_BIT_RUN_EN]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("run enable not written");

  property p_no_stop_off;
    @(posedge clk_sys) disable iff (!nrst)
      !run_en_ff [*3] |-> !sec_clock_stopped;
  endproperty
  a_no_stop_off: assert property (p_no_stop_off) else $error("stopped with protocol off");

  property p_d3;
    @(posedge clk_sys) disable iff (!nrst)
      !run_mode_ff && !pm_d3hot |=> run_state_ff == SCGC_RUN;
  endproperty
  a_d3: assert property (p_d3) else $error("stopped outside d3hot");

  property p_mode_wr;
    @(posedge clk_sys) disable iff (!nrst)
      wr_ctrl |=> run_mode_ff == $past(apb_req.pwdata[SCGC_BIT_RUN_MODE]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("run mode not written");

  property p_idle;
    @(posedge clk_sys) disable iff (!nrst)
      run_mode_ff && !(sec_bus_idle && !primary_req_pending) |=> run_state_ff == SCGC_RUN;
  endproperty
  a_idle: assert property (p_idle) else $error("stopped while bus busy");

  property p_capid;
    @(posedge clk_sys) disable iff (!nrst)
      setup_ph && hit_hdr |=> apb_rsp.prdata[7:0] == SCGC_CAP_ID && apb_rsp.pready;
  endproperty
  a_capid: assert property (p_capid) else $error("bad subsys_cap_identifier");

  property p_hdr_hi;
    @(posedge clk_sys) disable iff (!nrst)
      setup_ph && hit_hdr |=> apb_rsp.prdata[31:16] == 16'h0000;
  endproperty
  a_hdr_hi: assert property (p_hdr_hi) else $error("header upper half not zero");

  property p_next;
    @(posedge clk_sys) disable iff (!nrst)
      setup_ph && hit_hdr && !slot_id_en_ff |=> apb_rsp.prdata[15:8] == SCGC_NEXT_PCIE;
  endproperty
  a_next: assert property (p_next) else $error("bad next pointer");

  property p_next_slot;
    @(posedge clk_sys) disable iff (!nrst)
      setup_ph && hit_hdr && slot_id_en_ff |=> apb_rsp.prdata[15:8] == SCGC_NEXT_SLOT_ID;
  endproperty
  a_next_slot: assert property (p_next_slot) else $error("next pointer not redirected");

  property p_vid;
    @(posedge clk_sys) disable iff (!nrst)
      setup_ph && hit_card && loaded_ff |=> apb_rsp.prdata[15:0] == $past(card_vid_ff);
  endproperty
  a_vid: assert property (p_vid) else $error("bad vendor identifier");

  property p_sid;
    @(posedge clk_sys) disable iff (!nrst)
      setup_ph && hit_card && loaded_ff |=> apb_rsp.prdata[31:16] == $past(card_id_ff);
  endproperty
  a_sid: assert property (p_sid) else $error("bad subsystem identifier");

  property p_si_hold;
    @(posedge clk_sys) disable iff (!nrst)
      !cfgmem_load_valid |=> $stable(slot_id_en_ff);
  endproperty
  a_si_hold: assert property (p_si_hold) else $error("slot id changed without load");

  property p_rev;
    @(posedge clk_sys) disable iff (!nrst)
      !forward_mode |=> dev2_clock_out == secondary_clock_output && dev3_clock_out == secondary_clock_output &&
                        dev4_clock_out == secondary_clock_output && bridge_feedback_clock_out == secondary_clock_output;
  endproperty
  a_rev: assert property (p_rev) else $error("gate applied in reverse mode");

  property p_off_run;
    @(posedge clk_sys) disable iff (!nrst)
      !run_en_ff |=> run_state_ff == SCGC_RUN;
  endproperty
  a_off_run: assert property (p_off_run) else $error("stop state with protocol off");

  property p_err;
    @(posedge clk_sys) disable iff (!nrst)
      setup_ph && !mapped |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");

  c_stop:    cover property (@(posedge clk_sys) disable iff (!nrst)
    $rose(sec_clock_stopped));
  c_wake:    cover property (@(posedge clk_sys) disable iff (!nrst)
    $fell(sec_clock_stopped));
  c_si:      cover property (@(posedge clk_sys) disable iff (!nrst)
    $rose(slot_id_en_ff));
  c_rev:     cover property (@(posedge clk_sys) disable iff (!nrst)
    !forward_mode && secondary_clock_output);
  c_d3_stop: cover property (@(posedge clk_sys) disable iff (!nrst)
    sec_clock_stopped && !run_mode_ff);

endmodule // scgc_top

// File: verif/scgc_sec_bus_model.sv
`timescale 1ns/100ps
module scgc_sec_bus_model (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic busy_req,
  output logic      sec_bus_idle
);
  logic [2:0] hold_ff;

  // bus stays busy a few cycles after the last request
  always_ff @(posedge clk_sys) begin
    if (!nrst)
      hold_ff <= 3'h0;
    else if (busy_req)
      hold_ff <= 3'h5;
    else if (hold_ff != 3'h0)
      hold_ff <= hold_ff - 3'h1;
  end

  assign sec_bus_idle = (hold_ff == 3'h0) && !busy_req;
endmodule // scgc_sec_bus_model

// File: verif/scgc_top_tb.sv
`timescale 1ns/100ps
module scgc_top_tb;
  import scgc_pkg::*;
  logic          clk_sys = 1'b0;
  logic          nrst    = 1'b0;
  scgc_apb_req_s req     = '0;
  scgc_apb_rsp_s rsp;
  logic          fwd = 1'b1, d3 = 1'b0, pend = 1'b0, busy = 1'b0, ld = 1'b0, sid = 1'b0;
  logic [15:0]   lvid = 16'h0, lid = 16'h0;
  logic          idle, c2, c3, c4, cf, cs, stp, err, ex;
  logic [31:0]   rd, rnd;
  logic [4:0]    seen;
  logic [9:0]    corner [3] = '{10'h20f, 10'h00f, 10'h250};
  integer        seed = 8826, errors = 0, n_tests = 0, g;

  always #25 clk_sys = ~clk_sys;

  scgc_sec_bus_model part (.clk_sys(clk_sys), .nrst(nrst), .busy_req(busy), .sec_bus_idle(idle));
  scgc_top dut (.clk_sys(clk_sys), .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .forward_mode(fwd),
    .pm_d3hot(d3), .sec_bus_idle(idle), .primary_req_pending(pend), .cfgmem_load_valid(ld),
    .cfgmem_slot_id_en(sid), .cfgmem_card_vid(lvid), .cfgmem_card_id(lid), .dev2_clock_out(c2),
    .dev3_clock_out(c3), .dev4_clock_out(c4), .bridge_feedback_clock_out(cf),
    .secondary_clock_output(cs), .sec_clock_stopped(stp));

  function automatic logic exp_stop(logic en, logic mode, logic d3h, logic idl, logic pnd);
    return en & (mode ? (idl & !pnd) : d3h);
  endfunction

  function automatic logic [3:0] exp_run(logic [3:0] gate, logic fwd_m);
    return fwd_m ? ~gate : 4'hf;
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    integer w;
    w = 0;
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      w++;
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    chk("pready_wait", 32'h1, w);
    req <= '0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    close_out;
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    rdchk("ctrl_rst", SCGC_OFF_CLK_CTRL, 32'h0);
    rdchk("cap_hdr", SCGC_OFF_CAP_HDR, 32'h0000b00d);
    rdchk("card_id", SCGC_OFF_CARD_ID, 32'h3c3c5a5a);
    rdchk("slot_id_en", SCGC_OFF_SI_LOAD, 32'h0);
    apb(1'b1, SCGC_OFF_CAP_HDR, 32'hffffffff);
    rdchk("cap_hdr_ro", SCGC_OFF_CAP_HDR, 32'h0000b00d);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    for (int i = 0; i < 24; i++) begin
      rnd = $random(seed);
      if (i < 3)
        rnd = {22'h0, corner[i]};
      @(posedge clk_sys);
      fwd <= rnd[9];
      d3 <= rnd[6];
      pend <= rnd[7];
      busy <= rnd[8];
      apb(1'b1, SCGC_OFF_CLK_CTRL, {16'h0, rnd[5], rnd[4], 1'b0, rnd[3:0], 9'h0});
      ex = exp_stop(rnd[4], rnd[5], rnd[6], !rnd[8], rnd[7]);
      g = 0;
      while (stp !== ex && g < 20) begin
        @(posedge clk_sys);
        g++;
      end
      chk("stopped", {31'h0, ex}, {31'h0, stp});
      rdchk("ctrl", SCGC_OFF_CLK_CTRL, {16'h0, rnd[5:4], ex, rnd[3:0], 9'h0});
      seen = 5'h0;
      repeat (24) begin
        @(posedge clk_sys);
        seen = seen | {cs, cf, c4, c3, c2};
      end
      if (ex)
        chk("sec_clk", 32'h0, {27'h0, seen});
      else
        chk("clocks", {27'h0, 1'b1, exp_run(rnd[3:0], rnd[9])}, {27'h0, seen});
    end
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("stop_rst", 32'h0, {31'h0, stp});
    nrst <= 1'b1;
    rdchk("ctrl_rst2", SCGC_OFF_CLK_CTRL, 32'h0);
    rnd = $random(seed);
    @(posedge clk_sys);
    ld <= 1'b1;
    sid <= 1'b1;
    lvid <= rnd[15:0];
    lid <= rnd[31:16];
    @(posedge clk_sys);
    ld <= 1'b0;
    rdchk("next_slot", SCGC_OFF_CAP_HDR, 32'h0000a00d);
    rdchk("card_load", SCGC_OFF_CARD_ID, rnd);
    rdchk("slot_on", SCGC_OFF_SI_LOAD, 32'h1);
    close_out;
  end
endmodule // scgc_top_tb
